// ==== src/l2cms_defs.svh ====
// Register offsets, field positions, codes and timing counts for the
// cache maintenance sequencer. Included by package and design modules.
`ifndef L2CMS_DEFS_SVH
`define L2CMS_DEFS_SVH

// Register byte addresses; each 64-bit register spans two words
`define L2CMS_CTRL_LO 12'h620
`define L2CMS_CTRL_HI 12'h624
`define L2CMS_RANGE_LO 12'h628
`define L2CMS_RANGE_HI 12'h62c

// Control register low word fields
`define L2CMS_CMD_LSB 0
`define L2CMS_CMD_MSB 1
`define L2CMS_SEL_LSB 2
`define L2CMS_SEL_MSB 4
`define L2CMS_ACTIVE_BIT 5
`define L2CMS_OUT_LSB 6
`define L2CMS_OUT_MSB 8
`define L2CMS_INIT_DONE_BIT 30
`define L2CMS_PRESENT_BIT 31

// Range register: low word holds address bits 31:6, high word 47:32
`define L2CMS_ADDR_HI_MSB 15
`define L2CMS_COUNT_LSB 16
`define L2CMS_COUNT_MSB 31

// Command, operation and outcome codes
`define L2CMS_CMD_START 2'h1
`define L2CMS_SEL_FLUSH 3'h0
`define L2CMS_SEL_HIT_INV 3'h4
`define L2CMS_SEL_HIT_WRITEBACK_INVALIDATE 3'h5
`define L2CMS_SEL_HIT_WRITEBACK 3'h6
`define L2CMS_OUT_RUNNING 3'h0
`define L2CMS_OUT_OK 3'h1
`define L2CMS_OUT_ERROR 3'h2

// Reset values
`define L2CMS_SEL_RESET 3'h0
`define L2CMS_OUT_RESET 3'h0

// Timing: clock period and tag-init start delay, both in ns
`define L2CMS_CLK_NS 100
`define L2CMS_INIT_DELAY_NS 3200
`define L2CMS_INIT_DELAY_CYC \
  ((`L2CMS_INIT_DELAY_NS + `L2CMS_CLK_NS - 1) / `L2CMS_CLK_NS)

`endif

// ==== src/l2cms_pkg.sv ====
// Types shared by the cache maintenance sequencer modules.
// Assumes l2cms_defs.svh is on the include path.
package l2cms_pkg;
  `include "l2cms_defs.svh"

  typedef logic [2:0] l2cms_sel_t;
  typedef logic [2:0] l2cms_out_t;

  typedef enum logic [2:0] {
    ENG_IDLE,
    ENG_WAIT_INIT,
    ENG_ISSUE,
    ENG_WAIT_RSP
  } l2cms_eng_e;

  typedef enum logic [2:0] {
    INI_SAMPLE,
    INI_DELAY,
    INI_WALK,
    INI_DONE
  } l2cms_ini_e;
endpackage : l2cms_pkg

// ==== src/l2cms_init_if.sv ====
// Status carried from the tag-init sequencer to the maintenance engine.
// Both ends share pclk; no clocking.
`timescale 1ns/1ps
interface l2cms_init_if;
  logic busy;
  logic done;
  modport seq (output busy, output done);
  modport ctl (input busy, input done);
endinterface : l2cms_init_if

// ==== src/l2cms_tag_init.sv ====
// Automatic tag-array initialisation after reset.
// Assumes straps are stable around reset release and tag port is on pclk.
`timescale 1ns/1ps
`include "l2cms_defs.svh"
module l2cms_tag_init
  import l2cms_pkg::*;
#(
  parameter int TAG_ENTRIES = 8192,
  parameter int DELAY_CYC = `L2CMS_INIT_DELAY_CYC,
  parameter int IDX_W = $clog2(TAG_ENTRIES)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Straps and blockers
  input wire logic hw_init_inhibit,
  input wire logic hw_init_enable,
  input wire logic mbist_busy,
  // Tag clear port
  output logic tag_clr_valid,
  output logic [IDX_W-1:0] tag_clr_index,
  input wire logic tag_clr_ready,
  // Status to the engine
  l2cms_init_if.seq st
);
  l2cms_ini_e state;
  logic [31:0] delay_cnt;

  if (TAG_ENTRIES < 2 || DELAY_CYC < 1) begin : g_chk
    $error("l2cms_tag_init: bad TAG_ENTRIES or DELAY_CYC");
  end

  // Straps caught on the first clocked cycle after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= INI_SAMPLE;
      delay_cnt <= 32'h0;
      tag_clr_index <= '0;
    end else begin
      unique case (state)
        INI_SAMPLE: begin
          state <= (!hw_init_inhibit && hw_init_enable) ? INI_DELAY
                                                        : INI_DONE;
        end
        INI_DELAY: begin
          if (delay_cnt >= 32'(DELAY_CYC - 1) && !mbist_busy) begin
            state <= INI_WALK;
          end else if (delay_cnt < 32'(DELAY_CYC - 1)) begin
            delay_cnt <= delay_cnt + 32'h1;
          end
        end
        INI_WALK: begin
          if (tag_clr_ready) begin
            if (tag_clr_index == IDX_W'(TAG_ENTRIES - 1)) begin
              state <= INI_DONE;
            end else begin
              tag_clr_index <= tag_clr_index + IDX_W'(1);
            end
          end
        end
        INI_DONE: state <= INI_DONE;
      endcase
    end
  end

  assign tag_clr_valid = (state == INI_WALK);
  assign st.busy = (state != INI_DONE);
  assign st.done = (state == INI_DONE);
endmodule : l2cms_tag_init

// ==== src/l2cms_sequencer.sv ====
// Cache maintenance sequencer: APB registers, flush and ranged walk
// engine, and hold-off of coherent requests during tag init.
// Assumes APB master on pclk and a cache that acks each line op once.
`timescale 1ns/1ps
`include "l2cms_defs.svh"
// Function
// - Control register shows a read-only presence bit set to one.
// - Select field bits 4:2; code 0x0 flushes the whole cache.
// - Codes 0x4, 0x5, 0x6 select hit inv, wb-inv, wb per line.
// - Command field bits 1:0; writing 0x1 starts the selected operation.
// - Outcome bits 8:6 read 0x0 while running, 0x1 on clean finish.
// - Range start line address sits in range register bits 47:6.
// - Line count sits in range register bits 63:48.
// - Ranged walk applies the action to exactly the programmed count.
// - Maintenance starts only from a software command write.
// - Coherent requests are held out while tag init runs.
module l2cms_sequencer
  import l2cms_pkg::*;
#(
  parameter int CACHE_LINES = 131072,
  parameter int TAG_ENTRIES = 8192,
  parameter int INIT_DELAY_CYC = `L2CMS_INIT_DELAY_CYC,
  parameter int COH_W = 64
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Line maintenance requests to the cache
  output logic maint_req_valid,
  input wire logic maint_req_ready,
  output logic maint_req_flush,
  output logic [2:0] maint_req_op,
  output logic [47:6] maint_req_addr,
  input wire logic maint_rsp_valid,
  input wire logic maint_rsp_err,
  // Tag init straps, blockers and clear port
  input wire logic hw_init_inhibit,
  input wire logic hw_init_enable,
  input wire logic mbist_busy,
  output logic tag_clr_valid,
  output logic [$clog2(TAG_ENTRIES)-1:0] tag_clr_index,
  input wire logic tag_clr_ready,
  // Coherent request path into the pipeline
  input wire logic coh_in_valid,
  output logic coh_in_ready,
  input wire logic [COH_W-1:0] coh_in_data,
  output logic coh_out_valid,
  input wire logic coh_out_ready,
  output logic [COH_W-1:0] coh_out_data,
  // Status
  output logic init_busy
);
  localparam int LINE_W = $clog2(CACHE_LINES);

  if (CACHE_LINES < 2 || CACHE_LINES > (1 << 30) || COH_W < 1)
  begin : g_chk
    $error("l2cms_sequencer: unsupported CACHE_LINES or COH_W");
  end

  if (TAG_ENTRIES < 2 || INIT_DELAY_CYC < 1) begin : g_chk_init
    $error("l2cms_sequencer: unsupported TAG_ENTRIES or INIT_DELAY_CYC");
  end

  // Software-visible state
  l2cms_sel_t op_select;
  l2cms_out_t op_outcome;
  logic op_active;
  logic [47:6] range_start;
  logic [15:0] range_count;

  // Engine state
  l2cms_eng_e eng;
  l2cms_sel_t run_sel;
  logic [47:6] cur_addr;
  // One bit wider than the count so the walk cannot wrap
  logic [16:0] remaining;
  logic [LINE_W-1:0] flush_idx;
  logic run_err;

  // APB decode
  logic setup;
  logic wr_take;
  logic hit_ctrl_lo;
  logic hit_ctrl_hi;
  logic hit_rng_lo;
  logic hit_rng_hi;
  logic hit_any;
  logic start_cmd;
  logic [31:0] ctrl_lo_wdata;
  logic [31:0] rng_lo_wdata;
  logic [31:0] rng_hi_wdata;
  logic [31:0] rd_mux;

  // Init status reaches the engine through the interface
  l2cms_init_if init_st ();

  l2cms_tag_init #(
    .TAG_ENTRIES(TAG_ENTRIES),
    .DELAY_CYC(INIT_DELAY_CYC)
  ) u_tag_init (
    .pclk(pclk),
    .presetn(presetn),
    .hw_init_inhibit(hw_init_inhibit),
    .hw_init_enable(hw_init_enable),
    .mbist_busy(mbist_busy),
    .tag_clr_valid(tag_clr_valid),
    .tag_clr_index(tag_clr_index),
    .tag_clr_ready(tag_clr_ready),
    .st(init_st.seq)
  );

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_lanes

  // Per-line codes; anything else except flush is refused
  function automatic logic is_ranged(input l2cms_sel_t s);
    return s == `L2CMS_SEL_HIT_INV || s == `L2CMS_SEL_HIT_WRITEBACK_INVALIDATE ||
           s == `L2CMS_SEL_HIT_WRITEBACK;
  endfunction : is_ranged

  function automatic logic is_known(input l2cms_sel_t s);
    return s == `L2CMS_SEL_FLUSH || is_ranged(s);
  endfunction : is_known

  assign setup = psel && !penable;
  assign wr_take = psel && penable && pwrite;
  assign hit_ctrl_lo = paddr == `L2CMS_CTRL_LO;
  assign hit_ctrl_hi = paddr == `L2CMS_CTRL_HI;
  assign hit_rng_lo = paddr == `L2CMS_RANGE_LO;
  assign hit_rng_hi = paddr == `L2CMS_RANGE_HI;
  // Upper control word is mapped but reads zero
  assign hit_any = hit_ctrl_lo || hit_ctrl_hi || hit_rng_lo || hit_rng_hi;

  // Zero-wait slave: data and error are ready by the access phase
  assign pready = 1'b1;

  assign ctrl_lo_wdata = merge_lanes(32'h0, pwdata, pstrb);
  assign rng_lo_wdata = merge_lanes({range_start[31:6], 6'h0}, pwdata,
                                    pstrb);
  assign rng_hi_wdata = merge_lanes({range_count, range_start[47:32]},
                                    pwdata, pstrb);

  // Only a software write of the start code can launch the engine
  assign start_cmd = wr_take && hit_ctrl_lo && pstrb[0] &&
                     pwdata[`L2CMS_CMD_MSB:`L2CMS_CMD_LSB] ==
                     `L2CMS_CMD_START && !op_active;

  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl_lo) begin
      rd_mux[`L2CMS_PRESENT_BIT] = 1'b1;
      rd_mux[`L2CMS_INIT_DONE_BIT] = init_st.done;
      rd_mux[`L2CMS_SEL_MSB:`L2CMS_SEL_LSB] = op_select;
      rd_mux[`L2CMS_ACTIVE_BIT] = op_active;
      rd_mux[`L2CMS_OUT_MSB:`L2CMS_OUT_LSB] = op_outcome;
    end else if (hit_rng_lo) begin
      rd_mux = {range_start[31:6], 6'h0};
    end else if (hit_rng_hi) begin
      rd_mux = {range_count, range_start[47:32]};
    end
  end

  // Read data and error latched in the setup cycle
  // so prdata stands still through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0 : rd_mux;
      pslverr <= !hit_any;
    end
  end

  // Select field; frozen while an operation runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_select <= `L2CMS_SEL_RESET;
    end else if (wr_take && hit_ctrl_lo && pstrb[0] && !op_active) begin
      op_select <= ctrl_lo_wdata[`L2CMS_SEL_MSB:`L2CMS_SEL_LSB];
    end
  end

  // Range register; the engine copies it at start, so edits are safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_start <= '0;
      range_count <= 16'h0;
    end else if (wr_take && hit_rng_lo) begin
      range_start[31:6] <= rng_lo_wdata[31:6];
    end else if (wr_take && hit_rng_hi) begin
      range_start[47:32] <= rng_hi_wdata[`L2CMS_ADDR_HI_MSB:0];
      range_count <=
        rng_hi_wdata[`L2CMS_COUNT_MSB:`L2CMS_COUNT_LSB];
    end
  end

  // Select written together with the start command takes effect now
  l2cms_sel_t start_sel;
  assign start_sel = ctrl_lo_wdata[`L2CMS_SEL_MSB:`L2CMS_SEL_LSB];

  // Flush walks every index; a ranged walk counts down its copy
  logic last_line;
  logic finish;
  assign last_line = (run_sel == `L2CMS_SEL_FLUSH)
                     ? (flush_idx == LINE_W'(CACHE_LINES - 1))
                     : (remaining == 17'h1);

  // Walk engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng <= ENG_IDLE;
      run_sel <= `L2CMS_SEL_RESET;
      cur_addr <= '0;
      remaining <= 17'h0;
      flush_idx <= '0;
    end else begin
      unique case (eng)
        ENG_IDLE: begin
          if (start_cmd && is_known(start_sel)) begin
            run_sel <= start_sel;
            cur_addr <= range_start;
            remaining <= {1'b0, range_count};
            flush_idx <= '0;
            // Empty range finishes at once and never reaches the cache
            if (!is_ranged(start_sel) || range_count != 16'h0) begin
              eng <= ENG_WAIT_INIT;
            end
          end
        end
        ENG_WAIT_INIT: begin
          // Tag walk owns the arrays until it is finished
          if (!init_st.busy) begin
            eng <= ENG_ISSUE;
          end
        end
        ENG_ISSUE: begin
          if (maint_req_ready) begin
            eng <= ENG_WAIT_RSP;
          end
        end
        ENG_WAIT_RSP: begin
          if (maint_rsp_valid) begin
            if (last_line) begin
              eng <= ENG_IDLE;
            end else begin
              eng <= ENG_ISSUE;
              flush_idx <= flush_idx + LINE_W'(1);
              cur_addr <= cur_addr + 42'h1;
              remaining <= remaining - 17'h1;
            end
          end
        end
      endcase
    end
  end

  assign finish = eng == ENG_WAIT_RSP && maint_rsp_valid && last_line;

  // Error from any line makes the outcome an error
  // Cleared at start so an old error cannot taint the next run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_err <= 1'b0;
    end else if (start_cmd) begin
      run_err <= 1'b0;
    end else if (eng == ENG_WAIT_RSP && maint_rsp_valid && maint_rsp_err)
    begin
      run_err <= 1'b1;
    end
  end

  // Active and outcome: outcome reads running while active, and from reset until the first start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_active <= 1'b0;
      op_outcome <= `L2CMS_OUT_RESET;
    end else if (start_cmd) begin
      if (!is_known(start_sel)) begin
        op_outcome <= `L2CMS_OUT_ERROR;
      end else if (is_ranged(start_sel) && range_count == 16'h0) begin
        op_outcome <= `L2CMS_OUT_OK;
      end else begin
        op_active <= 1'b1;
        op_outcome <= `L2CMS_OUT_RUNNING;
      end
    end else if (finish) begin
      op_active <= 1'b0;
      op_outcome <= (run_err || maint_rsp_err) ? `L2CMS_OUT_ERROR
                                               : `L2CMS_OUT_OK;
    end
  end

  // Line request outputs
  assign maint_req_valid = (eng == ENG_ISSUE);
  assign maint_req_flush = (run_sel == `L2CMS_SEL_FLUSH);
  assign maint_req_op = run_sel;
  // Flush carries the line index in the address field
  always_comb begin
    maint_req_addr = cur_addr;
    if (run_sel == `L2CMS_SEL_FLUSH) begin
      maint_req_addr = 42'(flush_idx);
    end
  end

  // Coherent hold-off; data passes untouched, handshakes are gated
  // Data is left ungated: low valid is enough and saves a mux stage
  assign init_busy = init_st.busy;
  assign coh_out_valid = coh_in_valid && !init_st.busy;
  assign coh_in_ready = coh_out_ready && !init_st.busy;
  assign coh_out_data = coh_in_data;
endmodule : l2cms_sequencer

// ==== sim/l2cms_seq_sva.sv ====
// Port-level assertions for the cache maintenance sequencer.
// Assumes one pclk domain and asynchronous active-low presetn.
`timescale 1ns/1ps
module l2cms_seq_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Cache side and status
  input wire logic maint_req_valid,
  input wire logic maint_req_ready,
  input wire logic maint_req_flush,
  input wire logic [2:0] maint_req_op,
  input wire logic [47:6] maint_req_addr,
  input wire logic init_busy,
  input wire logic coh_in_ready,
  input wire logic coh_out_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_unmapped_err: assert property (psel && penable |->
    pslverr == !(paddr inside {12'h620, 12'h624, 12'h628, 12'h62c}))
    else $error("slverr wrong");
  chk_present_bit: assert property (psel && penable && !pwrite &&
    paddr == 12'h620 |-> prdata[31]) else $error("present bit low");
  chk_req_hold: assert property (maint_req_valid && !maint_req_ready
    |=> maint_req_valid && $stable(maint_req_addr)
    && $stable(maint_req_op)) else $error("request dropped or changed");
  chk_one_line: assert property (maint_req_valid && maint_req_ready
    |=> !maint_req_valid) else $error("second line before response");
  chk_init_no_req: assert property (init_busy |->
    !maint_req_valid) else $error("request during tag init");
  chk_coh_gated: assert property (init_busy |->
    !coh_out_valid && !coh_in_ready) else $error("coherent leak in init");
  chk_flush_code: assert property (maint_req_valid && maint_req_flush
    |-> maint_req_op == 3'h0) else $error("flush with wrong code");
  chk_ranged_code: assert property (maint_req_valid && !maint_req_flush
    |-> maint_req_op inside {3'h4, 3'h5, 3'h6}) else $error("bad op");
  chk_run_outcome: assert property (psel && penable && !pwrite &&
    paddr == 12'h620 && prdata[5] |-> prdata[8:6] == 3'h0)
    else $error("active with outcome set");

  cover property (maint_req_valid && maint_req_flush);
  cover property (maint_req_valid && maint_req_op == 3'h5);
  cover property ($fell(init_busy));
  cover property (maint_req_valid && maint_req_op == 3'h6);
endmodule : l2cms_seq_sva

bind l2cms_sequencer l2cms_seq_sva l2cms_seq_sva_inst (.pclk, .presetn,
  .paddr, .psel, .penable, .pwrite, .prdata, .pslverr, .maint_req_valid,
  .maint_req_ready, .maint_req_flush, .maint_req_op, .maint_req_addr,
  .init_busy, .coh_in_ready, .coh_out_valid);

// ==== sim/tb.sv ====
// Self-checking bench for the maintenance sequencer over APB.
// Assumes the bench also acts as cache, answering one cycle after accept.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  miscompares++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
  import l2cms_pkg::*;
  localparam int LINES = 16;
  localparam logic [47:0] START = 48'h0001_1234_5640;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf, wstrb = 4'hf;
  logic mbist_busy = 1'b1, tag_clr_valid;
  logic [2:0] tag_clr_index;
  logic pready, pslverr, maint_req_valid, maint_req_flush, init_busy;
  logic [31:0] prdata;
  logic [2:0] maint_req_op;
  logic [47:6] maint_req_addr;
  logic maint_req_ready = 1'b0, maint_rsp_valid = 1'b0, maint_rsp_err = 1'b0;
  logic tag_clr_ready = 1'b1, coh_out_ready = 1'b1, coh_in_valid = 1'b1;
  logic coh_in_ready, coh_out_valid, inject_err = 1'b0;
  logic [63:0] coh_in_data = 64'h0123_4567_89ab_cdef;
  logic [63:0] coh_out_data;
  logic [41:0] exp_addr = '0;
  logic [2:0] cur_sel = '0;
  logic [31:0] d;
  logic e;
  int req_cnt = 0, checks = 0, miscompares = 0, clr_cnt = 0;

  always #50 pclk = ~pclk;

  l2cms_sequencer #(.CACHE_LINES(LINES), .TAG_ENTRIES(8),
    .INIT_DELAY_CYC(1)) l2cms_sequencer_inst (.pclk, .presetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .maint_req_valid, .maint_req_ready, .maint_req_flush,
    .maint_req_op, .maint_req_addr, .maint_rsp_valid, .maint_rsp_err,
    .hw_init_inhibit(1'b0), .hw_init_enable(1'b1), .mbist_busy,
    .tag_clr_valid, .tag_clr_index, .tag_clr_ready, .coh_in_valid,
    .coh_in_ready, .coh_in_data, .coh_out_valid, .coh_out_ready,
    .coh_out_data, .init_busy);

  // Cache stand-in; ready toggles so requests must sometimes wait
  always @(posedge pclk) begin
    maint_rsp_valid <= maint_req_valid && maint_req_ready;
    maint_rsp_err <= inject_err;
    maint_req_ready <= ~maint_req_ready;
    if (maint_req_valid && maint_req_ready) begin
      `CHK("addr", exp_addr, maint_req_addr)
      `CHK("flush", cur_sel == 3'h0, maint_req_flush)
      `CHK("op", cur_sel, maint_req_op)
      exp_addr <= exp_addr + 42'h1;
      req_cnt <= req_cnt + 1;
    end
    if (tag_clr_valid && tag_clr_ready) begin
      `CHK("clr_idx", 3'(clr_cnt), tag_clr_index)
      clr_cnt <= clr_cnt + 1;
    end
  end

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= wstrb;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run_op(input logic [2:0] sel, input logic [15:0] cnt,
                        input logic [2:0] exp_out, input int exp_n);
    int n;
    n = req_cnt;
    cur_sel = sel;
    exp_addr = (sel == 3'h0) ? '0 : START[47:6];
    apb(1'b1, 12'h62c, {cnt, START[47:32]});
    apb(1'b0, 12'h620, '0);
    `CHK("pre_idle", 1'b0, d[5])
    apb(1'b1, 12'h620, {27'h0, sel, 2'h1});
    apb(1'b0, 12'h620, '0);
    if (exp_n > 0) `CHK("active", 1'b1, d[5])
    for (int i = 0; i < 200 && d[5] !== 1'b0; i++) apb(1'b0, 12'h620, '0);
    `CHK("done_idle", 1'b0, d[5])
    `CHK("outcome", exp_out, d[8:6])
    `CHK("lines", exp_n, req_cnt - n)
    $display("op %0h count %0d done", sel, cnt);
  endtask : run_op

  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("init_busy", 1'b1, init_busy)
    `CHK("coh_hold", 1'b0, coh_out_valid)
    `CHK("coh_rdy_hold", 1'b0, coh_in_ready)
    repeat (6) @(negedge pclk);
    `CHK("mbist_hold", 1'b1, init_busy)
    `CHK("mbist_clr", 1'b0, tag_clr_valid)
    @(posedge pclk);
    mbist_busy <= 1'b0;
    for (int i = 0; i < 100 && init_busy !== 1'b0; i++) @(negedge pclk);
    `CHK("clr_lines", 8, clr_cnt)
    `CHK("coh_pass", 1'b1, coh_out_valid)
    `CHK("coh_data", coh_in_data, coh_out_data)
    $display("init test done");
    apb(1'b0, 12'h620, '0);
    `CHK("present", 1'b1, d[31])
    `CHK("init_done", 1'b1, d[30])
    `CHK("idle", 1'b0, d[5])
    apb(1'b1, 12'h628, 32'h1234_567f);
    apb(1'b0, 12'h628, '0);
    `CHK("range_lo", START[31:0], d)
    apb(1'b1, 12'h62c, 32'h0003_0001);
    apb(1'b0, 12'h62c, '0);
    `CHK("range_hi", 32'h0003_0001, d)
    wstrb = 4'hc;
    apb(1'b1, 12'h62c, 32'h0005_ffff);
    wstrb = 4'hf;
    apb(1'b0, 12'h62c, '0);
    `CHK("strobe", 32'h0005_0001, d)
    apb(1'b0, 12'h630, '0);
    `CHK("slverr", 1'b1, e)
    `CHK("unmapped", 32'h0, d)
    $display("register test done");
    for (int s = 4; s <= 6; s++) run_op(3'(s), 16'h3, 3'h1, 3);
    run_op(3'h0, 16'h3, 3'h1, LINES);
    run_op(3'h4, 16'h0, 3'h1, 0);
    run_op(3'h1, 16'h3, 3'h2, 0);
    inject_err = 1'b1;
    run_op(3'h5, 16'h2, 3'h2, 2);
    inject_err = 1'b0;
    end_sim();
  end
endmodule : tb
